// file: pkg/sdpc_consts.svh
// timing counts and register layout constants for the power-down and set-point controller
`ifndef SDPC_CONSTS_SVH
`define SDPC_CONSTS_SVH

// register byte addresses
`define SDPC_ADDR_CTRL        4'h0
`define SDPC_ADDR_STATUS      4'h4
`define SDPC_ADDR_PARAM       4'h8
`define SDPC_ADDR_SWITCH      4'hC
// control register fields
`define SDPC_CTRL_WR_SEL      0
`define SDPC_CTRL_OP_SEL      1
`define SDPC_CTRL_BANK_OPEN   2
// reset value of every duplicated parameter set (unterminated, low frequency)
`define SDPC_PARAM_RESET      32'h0000_0000
// times in ns, and cycle counts derived from them at 10 ns per cycle
`define SDPC_CLK_PERIOD_NS    10
`define SDPC_EXIT_DELAY_NS    80
`define SDPC_EXIT_CYCLES      ((`SDPC_EXIT_DELAY_NS + `SDPC_CLK_PERIOD_NS - 1) / `SDPC_CLK_PERIOD_NS)
`define SDPC_SWITCH_TIME_NS   250
`define SDPC_SWITCH_CYCLES    (`SDPC_SWITCH_TIME_NS / `SDPC_CLK_PERIOD_NS)
// link clock periods of good pulse width needed before resume
`define SDPC_STABLE_PERIODS   2
// shortest gap between link clock edges counted as stopped (sys cycles)
`define SDPC_LINK_GAP_MAX     16
`endif

// file: pkg/sdpc_pkg.sv
// types for the power-down and set-point controller
package sdpc_pkg;
   typedef enum logic [3:0] {
      SDPC_RUN      = 4'b0001,
      SDPC_PD       = 4'b0010,
      SDPC_EXIT     = 4'b0100,
      SDPC_CLKWAIT  = 4'b1000
   } sdpc_state_t;
   typedef enum logic [1:0] {
      SDPC_PD_NONE   = 2'h0,
      SDPC_PD_IDLE   = 2'h1,
      SDPC_PD_ACTIVE = 2'h2
   } sdpc_pd_kind_t;
endpackage

// file: verilog/sdpc_sync.sv
// two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module sdpc_sync (
   // clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_rst_n,
   // level in and out
   input  wire logic i_async,
   output logic      o_sync
);
   logic meta;
   logic next_meta;
   logic next_sync;

   // -----------------------------
   // next values
   // -----------------------------
   always_comb begin
      next_meta = i_async;
      next_sync = meta;
   end

   // registers, meta read only by o_sync
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         meta   <= 1'b0;
         o_sync <= 1'b0;
      end else begin
         meta   <= next_meta;
         o_sync <= next_sync;
      end
   end
endmodule

// file: verilog/sdpc_top.sv
// power-down, clock stop and frequency set-point control of one memory channel
// Operation
// - clock-enable low with select low enters power-down; controller avoids bursts
// - no refresh work is done while in power-down
// - power-down ends when clock-enable is registered high
// - entry with all banks idle is idle power-down, else active
// - after a clock stop with enable high, resume after two good periods plus exit delay; power-down exit waits the exit delay only
// - two copies per parameter; write-select picks the accessed copy
// - writes through the non-operating set leave live parameters unchanged
// - toggling operating-select switches all parameters together within switch time
// - duplicated set holds latencies, burst, preambles, termination, reference values
// - reset selects set zero; both sets reset to low-frequency values
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "sdpc_consts.svh"
module sdpc_top
   import sdpc_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   // memory link pins
   input  wire logic        i_true_clock_input,
   input  wire logic        i_complement_clock_input,
   input  wire logic        i_clock_gate,
   input  wire logic        i_select,
   // refresh request from the refresh scheduler
   input  wire logic        i_refresh_req,
   // avalon-mm slave
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   // device state
   output logic             o_powerdown,
   output logic             o_active_pd,
   output logic             o_ready,
   output logic             o_refresh_go,
   output logic [31:0]      o_live_param
);
   // -----------------------------
   // input synchronisers
   // -----------------------------
   logic ck_t_s;
   logic ck_c_s;
   logic cke_s;
   logic cs_s;
   sdpc_sync u_sync_ckt (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_async(i_true_clock_input), .o_sync(ck_t_s));
   sdpc_sync u_sync_ckc (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_async(i_complement_clock_input),
                         .o_sync(ck_c_s));
   sdpc_sync u_sync_cke (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_async(i_clock_gate), .o_sync(cke_s));
   sdpc_sync u_sync_cs  (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_async(i_select), .o_sync(cs_s));

   // -----------------------------
   // link clock edge and health
   // -----------------------------
   logic       ck_q;
   logic [4:0] gap_cnt;
   logic [1:0] good_cnt;
   logic       ck_rise;
   logic       ck_ok;
   logic [4:0] next_gap_cnt;
   logic [1:0] next_good_cnt;

   // a period is good when both halves are seen and the gap stays short
   always_comb begin
      ck_rise       = ck_t_s & ~ck_q;
      ck_ok         = (gap_cnt < 5'(`SDPC_LINK_GAP_MAX)) && (ck_t_s != ck_c_s);
      next_gap_cnt  = (ck_t_s != ck_q) ? 5'h00 : ((gap_cnt == 5'h1F) ? gap_cnt : gap_cnt + 5'h01);
      next_good_cnt = good_cnt;
      if (!ck_ok) begin
         next_good_cnt = 2'h0;
      end else if (ck_rise && good_cnt != 2'(`SDPC_STABLE_PERIODS)) begin
         next_good_cnt = good_cnt + 2'h1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         ck_q     <= 1'b0;
         gap_cnt  <= 5'h1F;
         good_cnt <= 2'h0;
      end else begin
         ck_q     <= ck_t_s;
         gap_cnt  <= next_gap_cnt;
         good_cnt <= next_good_cnt;
      end
   end

   // -----------------------------
   // register file and set points
   // -----------------------------
   logic        wr_sel;
   logic        op_sel;
   logic        bank_open;
   logic [31:0] param_set [2];
   logic [31:0] live;
   logic [7:0]  sw_cnt;
   logic        next_wr_sel;
   logic        next_op_sel;
   logic        next_bank_open;
   logic [31:0] next_param_set [2];
   logic [31:0] next_live;
   logic [7:0]  next_sw_cnt;
   logic [31:0] next_rdata;
   logic        next_wait;
   logic        bus_go;

   // one wait state per access, then a single-cycle answer
   always_comb begin
      bus_go         = (i_avs_read | i_avs_write) & o_avs_waitrequest;
      next_wait      = ~bus_go;
      next_wr_sel    = wr_sel;
      next_op_sel    = op_sel;
      next_bank_open = bank_open;
      next_param_set = param_set;
      next_rdata     = o_avs_readdata;
      next_live      = live;
      next_sw_cnt    = (sw_cnt != 8'h00) ? sw_cnt - 8'h01 : sw_cnt;
      if (sw_cnt == 8'h01) begin
         next_live = param_set[op_sel];
      end
      if (bus_go && i_avs_write) begin
         unique case (i_avs_address)
            `SDPC_ADDR_CTRL: begin
               next_wr_sel    = i_avs_writedata[`SDPC_CTRL_WR_SEL];
               next_op_sel    = i_avs_writedata[`SDPC_CTRL_OP_SEL];
               next_bank_open = i_avs_writedata[`SDPC_CTRL_BANK_OPEN];
               if (i_avs_writedata[`SDPC_CTRL_OP_SEL] != op_sel) begin
                  next_sw_cnt = 8'(`SDPC_SWITCH_CYCLES);
               end
            end
            `SDPC_ADDR_PARAM: begin
               next_param_set[wr_sel] = i_avs_writedata;
               // a write in the last switch cycle must win over the copy made in that cycle
               if (wr_sel == op_sel && sw_cnt < 8'h02) begin
                  next_live = i_avs_writedata;
               end
            end
            default: begin
            end
         endcase
      end
      if (bus_go && i_avs_read) begin
         unique case (i_avs_address)
            `SDPC_ADDR_CTRL:   next_rdata = {29'h0, bank_open, op_sel, wr_sel};
            `SDPC_ADDR_STATUS: next_rdata = {26'h0, o_refresh_go, o_ready, o_active_pd, o_powerdown, ck_ok, cke_s};
            `SDPC_ADDR_PARAM:  next_rdata = param_set[wr_sel];
            `SDPC_ADDR_SWITCH: next_rdata = {24'h0, sw_cnt};
            default:           next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         wr_sel            <= 1'b0;
         op_sel            <= 1'b0;
         bank_open         <= 1'b0;
         param_set[0]      <= `SDPC_PARAM_RESET;
         param_set[1]      <= `SDPC_PARAM_RESET;
         live              <= `SDPC_PARAM_RESET;
         sw_cnt            <= 8'h00;
         o_avs_readdata    <= 32'h0000_0000;
         o_avs_waitrequest <= 1'b1;
      end else begin
         wr_sel            <= next_wr_sel;
         op_sel            <= next_op_sel;
         bank_open         <= next_bank_open;
         param_set         <= next_param_set;
         live              <= next_live;
         sw_cnt            <= next_sw_cnt;
         o_avs_readdata    <= next_rdata;
         o_avs_waitrequest <= next_wait;
      end
   end

   // -----------------------------
   // power-down state machine
   // -----------------------------
   sdpc_state_t   state;
   sdpc_state_t   next_state;
   sdpc_pd_kind_t pd_kind;
   sdpc_pd_kind_t next_pd_kind;
   logic [3:0]    exit_cnt;
   logic [3:0]    next_exit_cnt;
   logic          cke_q;
   logic          next_ready;
   logic          next_refresh_go;

   // run, power-down, exit delay, and wait for a good clock after a stop
   always_comb begin
      next_state      = state;
      next_pd_kind    = pd_kind;
      next_exit_cnt   = exit_cnt;
      next_ready      = 1'b0;
      next_refresh_go = 1'b0;
      unique case (state)
         SDPC_RUN: begin
            next_ready      = ck_ok;
            next_refresh_go = i_refresh_req & ck_ok;
            if (!cke_s && !cs_s && cke_q) begin
               next_state   = SDPC_PD;
               next_pd_kind = bank_open ? SDPC_PD_ACTIVE : SDPC_PD_IDLE;
               // the entry cycle already shows power-down, so nothing is issued in it
               next_ready      = 1'b0;
               next_refresh_go = 1'b0;
            end else if (cke_s && !ck_ok) begin
               next_state = SDPC_CLKWAIT;
            end
         end
         SDPC_PD: begin
            next_refresh_go = 1'b0;
            if (cke_s) begin
               next_state    = SDPC_EXIT;
               next_pd_kind  = SDPC_PD_NONE;
               next_exit_cnt = 4'(`SDPC_EXIT_CYCLES);
            end
         end
         SDPC_EXIT: begin
            if (exit_cnt == 4'h1) begin
               next_state = SDPC_RUN;
            end
            next_exit_cnt = exit_cnt - 4'h1;
         end
         SDPC_CLKWAIT: begin
            if (good_cnt == 2'(`SDPC_STABLE_PERIODS)) begin
               next_state    = SDPC_EXIT;
               next_exit_cnt = 4'(`SDPC_EXIT_CYCLES);
            end
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         state        <= SDPC_RUN;
         pd_kind      <= SDPC_PD_NONE;
         exit_cnt     <= 4'h0;
         cke_q        <= 1'b0;
         o_powerdown  <= 1'b0;
         o_active_pd  <= 1'b0;
         o_ready      <= 1'b0;
         o_refresh_go <= 1'b0;
         o_live_param <= `SDPC_PARAM_RESET;
      end else begin
         state        <= next_state;
         pd_kind      <= next_pd_kind;
         exit_cnt     <= next_exit_cnt;
         cke_q        <= cke_s;
         o_powerdown  <= (next_state == SDPC_PD);
         o_active_pd  <= (next_pd_kind == SDPC_PD_ACTIVE);
         o_ready      <= next_ready;
         o_refresh_go <= next_refresh_go;
         o_live_param <= live;
      end
   end

   // -----------------------------
   // assertions
   // -----------------------------
   a_no_pd_refresh: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_powerdown |-> !o_refresh_go) else $error("refresh issued in power-down");
   a_pd_exit_time: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (state == SDPC_PD && cke_s) |=> (state == SDPC_EXIT)) else $error("power-down exit missed");
   a_pd_kind_sel: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (state == SDPC_RUN && next_state == SDPC_PD) |=> (pd_kind == ($past(bank_open) ? SDPC_PD_ACTIVE : SDPC_PD_IDLE)))
      else $error("wrong power-down kind");
   a_exit_delay: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (state != SDPC_EXIT ##1 state == SDPC_EXIT) |-> (state == SDPC_EXIT) [*8] ##1 state == SDPC_RUN)
      else $error("exit delay length wrong");
   a_rd_select: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (bus_go && i_avs_read && i_avs_address == `SDPC_ADDR_PARAM) |=> o_avs_readdata == $past(param_set[wr_sel]))
      else $error("read from wrong set");
   a_live_keep: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (bus_go && i_avs_write && i_avs_address == `SDPC_ADDR_PARAM && wr_sel != op_sel && sw_cnt == 8'h00)
      |=> $stable(live)) else $error("live set changed by other set write");
   a_switch_bound: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $changed(op_sel) |-> ##[0:25] (live == param_set[op_sel])) else $error("set switch incomplete");
   a_live_follow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (bus_go && i_avs_write && i_avs_address == `SDPC_ADDR_PARAM && wr_sel == op_sel && sw_cnt == 8'h00)
      |=> (live == $past(i_avs_writedata))) else $error("live set missed operating set write");
   a_pd_entry: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      ($fell(cke_s) && !cs_s && state == SDPC_RUN) |=> o_powerdown) else $error("power-down entry missed");
   a_pd_ready_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_powerdown |-> !o_ready) else $error("ready shown in power-down");
   a_clkwait_ready: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (state == SDPC_CLKWAIT) |-> !o_ready) else $error("ready shown while clock is bad");
   a_one_wait: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      bus_go |=> !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("bus answer timing wrong");
endmodule

// file: dv/sdpc_ctl_model.sv
// memory controller model: link clock, clock-enable and select pins
`timescale 1ns/1ps
module sdpc_ctl_model (
   // system clock
   input  wire logic i_clk_sys,
   // requests from the bench
   input  wire logic i_clk_run,
   input  wire logic i_gate_req,
   input  wire logic i_sel_req,
   // link pins
   output logic      o_true_clock_input,
   output logic      o_complement_clock_input,
   output logic      o_clock_gate,
   output logic      o_select
);
   // link clock of 80 ns, free phase; parked true low when stopped, never floated
   initial begin
      o_true_clock_input = 1'b0;
      #7;
      forever begin
         #40;
         o_true_clock_input = i_clk_run ? ~o_true_clock_input : 1'b0;
      end
   end
   assign o_complement_clock_input = ~o_true_clock_input;
   // gate follows the request; select held low around gate moves and clock stops
   initial begin
      o_clock_gate = 1'b1;
      o_select     = 1'b0;
   end
   always @(posedge i_clk_sys) begin
      o_clock_gate <= i_gate_req;
      o_select     <= (i_gate_req && o_clock_gate && i_clk_run) ? i_sel_req : 1'b0;
   end
endmodule

// file: dv/tb_sdpc_top.sv
// self-checking bench for the power-down and set-point controller
`timescale 1ns/1ps
`include "sdpc_consts.svh"
module tb_sdpc_top;
   logic        clk, rst_n, run, gate_rq, sel_rq, rf_req, rd, wr, ws, op;
   logic        wreq, pd, apd, rdy, rgo, tck, cck, gate, sel;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, live, d;
   logic [31:0] eset [2];
   int          err_count, checked, n, seed;
   // --------------------------------------------------------------------
   // instances and clock
   // --------------------------------------------------------------------
   sdpc_ctl_model i_sdpc_ctl_model (.i_clk_sys(clk), .i_clk_run(run), .i_gate_req(gate_rq),
      .i_sel_req(sel_rq), .o_true_clock_input(tck), .o_complement_clock_input(cck),
      .o_clock_gate(gate), .o_select(sel));
   sdpc_top i_sdpc_top (.i_clk_sys(clk), .i_rst_n(rst_n), .i_true_clock_input(tck),
      .i_complement_clock_input(cck), .i_clock_gate(gate), .i_select(sel), .i_refresh_req(rf_req),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_powerdown(pd), .o_active_pd(apd),
      .o_ready(rdy), .o_refresh_go(rgo), .o_live_param(live));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // --------------------------------------------------------------------
   // checking, expectations and bus tasks
   // --------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic [31:0] st(input logic g, k, p, a, r, f);
      return {26'h0, f, r, a, p, k, g};
   endfunction
   function automatic logic [31:0] ctl(input logic w, o, b);
      return {29'h0, b, o, w};
   endfunction
   // one access, held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v, output logic [31:0] r);
      int k;
      k = 0;
      @(posedge clk);
      addr  <= a;
      wr    <= w;
      rd    <= ~w;
      wdata <= v;
      do begin
         @(posedge clk);
         k++;
      end while (wreq !== 1'b0 && k < 50);
      r = rdata;
      if (k >= 50) begin
         err_count++;
         test_done();
      end
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] v);
      logic [31:0] r;
      bus(1'b1, a, v, r);
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask
   // bounded wait on power-down (0), ready (1) or live set matching (2)
   task automatic wait_on(input int s, input logic v, output int c);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while ((s == 0 ? pd : s == 1 ? rdy : live === eset[op]) !== v && c < 200);
      if (c >= 200) begin
         err_count++;
         test_done();
      end
   endtask
   // power-down with bank state b, optional clock stop while gated off
   task automatic pdown(input logic b, input logic stop);
      wreg(`SDPC_ADDR_CTRL, ctl(1'b0, op, b));
      gate_rq <= 1'b0;
      wait_on(0, 1'b1, n);
      chk(apd, b);
      chk(rgo, 1'b0);
      rchk(`SDPC_ADDR_STATUS, st(1'b0, 1'b1, 1'b1, b, 1'b0, 1'b0));
      repeat (32) @(posedge clk);
      run <= ~stop;
      repeat (40) @(posedge clk);
      run <= 1'b1;
      repeat (24) @(posedge clk);
      chk(pd, 1'b1);
      gate_rq <= 1'b1;
      wait_on(1, 1'b1, n);
      chk(n >= `SDPC_EXIT_CYCLES, 1'b1);
      chk(pd, 1'b0);
      repeat (24) @(posedge clk);
      $display("test power-down bank %0d stop %0d done", b, stop);
   endtask
   // --------------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------------
   initial begin
      seed = 32'hC8B1A15F;
      {rst_n, rf_req, rd, wr, sel_rq, op} = 6'h00;
      {run, gate_rq} = 2'h3;
      addr = 4'h0;
      wdata = 32'h0;
      err_count = 0;
      checked = 0;
      eset[0] = `SDPC_PARAM_RESET;
      eset[1] = `SDPC_PARAM_RESET;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      chk(live, `SDPC_PARAM_RESET);
      rchk(`SDPC_ADDR_CTRL, ctl(1'b0, 1'b0, 1'b0));
      rchk(`SDPC_ADDR_PARAM, `SDPC_PARAM_RESET);
      rchk(4'h2, 32'h0);
      wait_on(1, 1'b1, n);
      rf_req <= 1'b1;
      repeat (3) @(negedge clk);
      chk(rgo, 1'b1);
      rchk(`SDPC_ADDR_STATUS, st(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1));
      $display("test reset done");
      // random writes to both sets, with operating-set toggles among them
      for (int i = 0; i < 9; i++) begin
         ws = 1'($random(seed));
         d = (i == 0) ? 32'hFFFFFFFF : $random(seed);
         sel_rq <= 1'($random(seed));
         wreg(`SDPC_ADDR_CTRL, ctl(ws, op, 1'b0));
         wreg(`SDPC_ADDR_PARAM, d);
         eset[ws] = d;
         @(negedge clk);
         chk(live, eset[op]);
         rchk(`SDPC_ADDR_PARAM, d);
         if (i % 3 == 2) begin
            op = ~op;
            wreg(`SDPC_ADDR_CTRL, ctl(ws, op, 1'b0));
            wait_on(2, 1'b1, n);
            chk(n <= `SDPC_SWITCH_CYCLES + 2, 1'b1);
            rchk(`SDPC_ADDR_SWITCH, 32'h0);
         end
      end
      $display("test set points done");
      pdown(1'b0, 1'b0);
      pdown(1'b1, 1'b1);
      // clock stop with the gate high
      run <= 1'b0;
      wait_on(1, 1'b0, n);
      chk(pd, 1'b0);
      @(posedge clk);
      run <= 1'b1;
      wait_on(1, 1'b1, n);
      chk(n >= (`SDPC_STABLE_PERIODS - 1) * 8 + `SDPC_EXIT_CYCLES, 1'b1);
      // parameters rewritten for the new clock go straight into the live set
      wreg(`SDPC_ADDR_CTRL, ctl(op, op, 1'b1));
      wreg(`SDPC_ADDR_PARAM, 32'h0000_00A5);
      @(negedge clk);
      chk(live, 32'h0000_00A5);
      $display("test clock stop done");
      test_done();
   end
endmodule
